// File: rtl/riosm_mapper.v
// Purpose: maps 16 link command bits to control functions and
//          builds 16 link status bits from internal states
// Assumes: single clock pclk, apb master holds request until pready
// Notes:   every function output is registered, one cycle behind
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "riosm_consts.vh"

// Functional notes
// - each command bit picks its function by code
// - default command map: select, run, stop, brake
// - each status bit picks its source by code
// - default status map: echoes, flags, busy
// - forward and backward bits are run requests
// - stop style bit: 0 instant, 1 decelerate
// - brake held at 0, released at 1
// - panel unlock 1 lifts tool limitation
// - sixteen general bits, echoed on status
// - four select bits form data number
// - torque cap enable 1 enables limiting
// - duplicated run, stop, brake, select or general function ORs its positions
// - unassigned panel or torque cap reads 1
// - multiple panel or torque terminals AND
// - echo status reports current command function
// - fault flag is 1 while alarm present
// - warning flag is 1 while warning present
// - moving bit is 1 while motor operates
// - torque capped and speed reached flags
// - internal busy bit follows internal processing
// - overload flag set on overload condition
// - main supply and turn sense status
module riosm_mapper (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        direct_panel_assigned,
  input  wire        direct_panel_unlock,
  input  wire        direct_torque_assigned,
  input  wire        direct_torque_cap,
  input  wire        alarm_present,
  input  wire        warning_present,
  input  wire        motor_moving,
  input  wire        torque_at_limit,
  input  wire        speed_at_set,
  input  wire        internal_busy_in,
  input  wire        overload_present,
  input  wire        main_supply_on,
  input  wire        turn_forward,
  output wire        forward_run,
  output wire        backward_run,
  output wire        stop_decel,
  output wire        brake_release,
  output wire        panel_unlock,
  output wire        torque_cap_enable,
  output wire [3:0]  data_select,
  output wire [15:0] general_bit,
  output wire [15:0] link_status_bit
);

  reg  [15:0] cmd_reg;
  reg  [4:0]  in_map_reg  [0:15];
  reg  [5:0]  out_map_reg [0:15];
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg  [15:0] status_reg;
  reg  [25:0] ctl_reg;
  reg  [31:0] in_hit;
  reg  [31:0] in_asg;
  reg  [31:0] in_all;
  reg  [31:0] in_miss;
  reg  [63:0] out_src;
  reg  [31:0] rd_next;
  reg         err_next;
  reg  [15:0] status_next;
  reg  [25:0] ctl_next;
  reg         panel_net;
  reg         torque_net;
  integer     k;
  integer     j;
  wire [11:0] in_base  = `RIOSM_IN_MAP_BASE;
  wire [11:0] out_base = `RIOSM_OUT_MAP_BASE;

  wire        access  = psel & penable;
  wire        sel_cmd = (paddr == `RIOSM_CMD_OFS);
  wire        sel_st  = (paddr == `RIOSM_STAT_OFS);
  wire        sel_in  = (paddr[11:6] == in_base[11:6]) &
                        (paddr[1:0] == 2'h0);
  wire        sel_out = (paddr[11:6] == out_base[11:6]) &
                        (paddr[1:0] == 2'h0);
  wire [3:0]  map_idx = paddr[5:2];
  wire        wr_go   = access & pwrite & pready_reg;

  // default command map
  function [4:0] in_default;
    input integer pos;
    begin
      case (pos)
        0:       in_default = `RIOSM_IN_DSEL0;
        1:       in_default = `RIOSM_IN_DSEL0 + 5'h01;
        2:       in_default = `RIOSM_IN_DSEL0 + 5'h02;
        3:       in_default = `RIOSM_IN_FWD;
        4:       in_default = `RIOSM_IN_REV;
        5:       in_default = `RIOSM_IN_STOP;
        6:       in_default = `RIOSM_IN_BRAKE;
        default: in_default = `RIOSM_IN_NONE;
      endcase
    end
  endfunction

  // default status map
  function [5:0] out_default;
    input integer pos;
    begin
      case (pos)
        0:       out_default = `RIOSM_OUT_DSEL_E0;
        1:       out_default = `RIOSM_OUT_DSEL_E0 + 6'h01;
        2:       out_default = `RIOSM_OUT_DSEL_E0 + 6'h02;
        3:       out_default = `RIOSM_OUT_FWD_E;
        4:       out_default = `RIOSM_OUT_REV_E;
        5:       out_default = `RIOSM_OUT_STOP_E;
        6:       out_default = `RIOSM_OUT_WARN;
        7:       out_default = `RIOSM_OUT_FAULT;
        8:       out_default = `RIOSM_OUT_BUSY;
        12:      out_default = `RIOSM_OUT_OVLD;
        13:      out_default = `RIOSM_OUT_MOVE;
        14:      out_default = `RIOSM_OUT_SPEED;
        15:      out_default = `RIOSM_OUT_TCAP;
        default: out_default = `RIOSM_OUT_NONE;
      endcase
    end
  endfunction

  // per position map registers
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_map
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_map_reg[g]  <= in_default(g);
          out_map_reg[g] <= out_default(g);
        end else if (wr_go && map_idx == g) begin
          if (sel_in)
            in_map_reg[g] <= pwdata[4:0];
          if (sel_out)
            out_map_reg[g] <= pwdata[5:0];
        end
      end
    end
  endgenerate

  // command word written by the link master
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cmd_reg <= `RIOSM_CMD_RST;
    else if (wr_go && sel_cmd)
      cmd_reg <= pwdata[15:0];
  end

  // one wait state so read data can come from a flip-flop
  always @* begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    if (sel_cmd)
      rd_next = {16'h0000, cmd_reg};
    else if (sel_st)
      rd_next = {16'h0000, status_reg};
    else if (sel_in)
      rd_next = {27'h0, in_map_reg[map_idx]};
    else if (sel_out)
      rd_next = {26'h0, out_map_reg[map_idx]};
    else
      err_next = 1'b1;
    if (sel_st && pwrite)
      err_next = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (access && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= err_next;
      prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // gather command functions; code 0 lands in bit 0 and is never read
  always @* begin
    in_hit = 32'h0000_0000;
    in_asg = 32'h0000_0000;
    in_miss = 32'h0000_0000;
    for (k = 0; k < 16; k = k + 1) begin
      in_asg[in_map_reg[k]] = 1'b1;
      if (cmd_reg[k])
        in_hit[in_map_reg[k]] = 1'b1;
      else
        in_miss[in_map_reg[k]] = 1'b1;
    end
    // any assigned position at 0 vetoes the function
    in_all     = ~in_miss;
    panel_net  = in_all[`RIOSM_IN_PANEL];
    torque_net = in_all[`RIOSM_IN_TORQ];
  end

  // layout of ctl: gen[15:0], torq, dsel[3:0], panel, brake, stop, rev, fwd
  always @* begin
    ctl_next[0] = in_hit[`RIOSM_IN_FWD];
    ctl_next[1] = in_hit[`RIOSM_IN_REV];
    ctl_next[2] = in_hit[`RIOSM_IN_STOP];
    ctl_next[3] = in_hit[`RIOSM_IN_BRAKE];
    // unassigned everywhere reads 1; else all assigned terminals must be 1
    ctl_next[4] = panel_net &
                  (~direct_panel_assigned | direct_panel_unlock);
    ctl_next[8:5] = in_hit[`RIOSM_IN_DSEL0 +: 4];
    ctl_next[9] = torque_net &
                  (~direct_torque_assigned | direct_torque_cap);
    ctl_next[25:10] = in_hit[`RIOSM_IN_GEN0 +: 16];
  end

  // status sources by output code
  always @* begin
    out_src = 64'h0000_0000_0000_0000;
    out_src[`RIOSM_OUT_FWD_E]   = ctl_reg[0];
    out_src[`RIOSM_OUT_REV_E]   = ctl_reg[1];
    out_src[`RIOSM_OUT_STOP_E]  = ctl_reg[2];
    out_src[`RIOSM_OUT_BRAKE_E] = ctl_reg[3];
    out_src[`RIOSM_OUT_PANEL_E] = ctl_reg[4];
    out_src[`RIOSM_OUT_DSEL_E0 +: 4] = ctl_reg[8:5];
    out_src[`RIOSM_OUT_TORQ_E]  = ctl_reg[9];
    out_src[`RIOSM_OUT_FAULT]   = alarm_present;
    out_src[`RIOSM_OUT_WARN]    = warning_present;
    out_src[`RIOSM_OUT_MOVE]    = motor_moving;
    out_src[`RIOSM_OUT_TCAP]    = torque_at_limit;
    out_src[`RIOSM_OUT_SPEED]   = speed_at_set;
    out_src[`RIOSM_OUT_BUSY]    = internal_busy_in;
    out_src[`RIOSM_OUT_OVLD]    = overload_present;
    out_src[`RIOSM_OUT_MAINS]   = main_supply_on;
    out_src[`RIOSM_OUT_DIR]     = turn_forward;
    out_src[`RIOSM_OUT_GEN_E0 +: 16] = ctl_reg[25:10];
    out_src[`RIOSM_OUT_NONE]    = 1'b0;
    for (j = 0; j < 16; j = j + 1)
      status_next[j] = out_src[out_map_reg[j]];
  end

  // echoes follow the registered functions, so they trail functions by one and commands by two
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg    <= 26'h0;
      status_reg <= 16'h0000;
    end else begin
      ctl_reg    <= ctl_next;
      status_reg <= status_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign forward_run       = ctl_reg[0];
  assign backward_run      = ctl_reg[1];
  assign stop_decel        = ctl_reg[2];
  assign brake_release     = ctl_reg[3];
  assign panel_unlock      = ctl_reg[4];
  assign data_select       = ctl_reg[8:5];
  assign torque_cap_enable = ctl_reg[9];
  assign general_bit       = ctl_reg[25:10];
  assign link_status_bit   = status_reg;

endmodule // riosm_mapper

// File: common/riosm_consts.vh
// Purpose: constants for the remote io signal mapper
// Assumes: apb slave, 32-bit data, word aligned registers
// Notes:   function codes pick what each link bit carries
`ifndef RIOSM_CONSTS_VH
`define RIOSM_CONSTS_VH

// register byte offsets
`define RIOSM_CMD_OFS        12'h000
`define RIOSM_STAT_OFS       12'h004
`define RIOSM_IN_MAP_BASE    12'h040
`define RIOSM_OUT_MAP_BASE   12'h080
`define RIOSM_MAP_SPAN       12'h040

// field widths
`define RIOSM_IN_CODE_W      5
`define RIOSM_OUT_CODE_W     6

// input function codes
`define RIOSM_IN_NONE        5'h00
`define RIOSM_IN_FWD         5'h01
`define RIOSM_IN_REV         5'h02
`define RIOSM_IN_STOP        5'h03
`define RIOSM_IN_BRAKE       5'h04
`define RIOSM_IN_PANEL       5'h05
`define RIOSM_IN_DSEL0       5'h06
`define RIOSM_IN_TORQ        5'h0a
`define RIOSM_IN_GEN0        5'h10

// output function codes
`define RIOSM_OUT_NONE       6'h00
`define RIOSM_OUT_FWD_E      6'h01
`define RIOSM_OUT_REV_E      6'h02
`define RIOSM_OUT_STOP_E     6'h03
`define RIOSM_OUT_BRAKE_E    6'h04
`define RIOSM_OUT_PANEL_E    6'h05
`define RIOSM_OUT_DSEL_E0    6'h06
`define RIOSM_OUT_TORQ_E     6'h0a
`define RIOSM_OUT_FAULT      6'h0b
`define RIOSM_OUT_WARN       6'h0c
`define RIOSM_OUT_MOVE       6'h0d
`define RIOSM_OUT_TCAP       6'h0e
`define RIOSM_OUT_SPEED      6'h0f
`define RIOSM_OUT_BUSY       6'h10
`define RIOSM_OUT_OVLD       6'h11
`define RIOSM_OUT_MAINS      6'h12
`define RIOSM_OUT_DIR        6'h13
`define RIOSM_OUT_GEN_E0     6'h20

// reset value of the command word
`define RIOSM_CMD_RST        16'h0000

`endif

// File: test/riosm_mapper_sva.sv
// Purpose: port checks for the mapper
// Assumes: apb answers after one wait
// Notes:   maps are writable, so only map-free relations
`timescale 1ns/1ps
module riosm_mapper_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        direct_panel_assigned,
  input wire logic        direct_panel_unlock,
  input wire logic        panel_unlock,
  input wire logic        forward_run,
  input wire logic        backward_run,
  input wire logic [3:0]  data_select,
  input wire logic [15:0] general_bit
);
  logic [15:0] cmd_reg;
  logic        wr_reg;
  logic        wr_d;
  wire         done = psel && penable && pready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 16'h0000;
      wr_reg  <= 1'b0;
      wr_d    <= 1'b0;
    end else begin
      wr_reg <= done && pwrite;
      wr_d   <= wr_reg;
      if (done && pwrite && paddr == 12'h000)
        cmd_reg <= pwdata[15:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_one_wait: assert property (
    psel && penable && !pready |=> pready) else $error("no answer");
  chk_pulse_once: assert property (
    pready |=> !pready) else $error("ready too long");
  chk_idle_quiet: assert property (
    !psel |=> !pready) else $error("ready while idle");
  chk_err_paired: assert property (
    pslverr |-> pready) else $error("error without ready");
  chk_status_ro: assert property (
    psel && penable && !pready && pwrite && paddr == 12'h004 |=> pslverr)
    else $error("status write accepted");
  chk_cmd_read: assert property (
    done && !pwrite && paddr == 12'h000 |-> prdata == {16'h0000, cmd_reg})
    else $error("command readback wrong");
  chk_funcs_hold: assert property (
    !wr_d |-> $stable({forward_run, backward_run, data_select,
                         general_bit})) else $error("function moved");
  chk_zero_cmd: assert property (
    cmd_reg == 16'h0000 && !wr_reg |-> !forward_run && !backward_run
      && general_bit == 16'h0000) else $error("run without command");
  chk_panel_and: assert property (
    direct_panel_assigned && !direct_panel_unlock |=> !panel_unlock)
    else $error("panel unlock ignores terminal");
endmodule // riosm_mapper_sva

bind riosm_mapper riosm_mapper_sva i_sva (.*);

// File: test/riosm_link_master.sv
// Purpose: link master model, writes commands over apb
// Assumes: slave answers with pready at a rising edge
// Notes:   released address and data show the inverse value
`timescale 1ns/1ps
module riosm_link_master (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [11:0]      paddr   = 12'h000,
  output logic [31:0]      pwdata  = 32'h00000000
);
  task automatic xfer(input logic we, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err, output logic ok);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= we;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // request stands until pready is seen high at a rising edge, or for at most 20 edges
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 20);
    q = prdata;
    err = pslverr;
    ok = pready;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // riosm_link_master

// File: test/tb_riosm_mapper.sv
// Purpose: self-checking bench for the mapper
// Assumes: one wait state apb, functions settle in 1 cycle and status in 2
// Notes:   a reference model mirrors both maps and the command
`timescale 1ns/1ps
module tb_riosm_mapper;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [12:0] st = 13'h0000;
  logic        psel, penable, pwrite, pready, pslverr, err, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] cmd = 16'h0000;
  wire  [5:0]  fn;
  wire  [3:0]  dsel;
  wire  [15:0] gen, stat;
  int miscompares = 0;
  int num_checks = 0;
  int dimap[16] = '{6, 7, 8, 1, 2, 3, 4, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  int domap[16] = '{6, 7, 8, 1, 2, 3, 12, 11, 16, 0, 0, 0, 17, 13, 15, 14};
  int imap[16], omap[16];
  riosm_mapper i_riosm_mapper (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .direct_panel_assigned(st[12]), .direct_panel_unlock(st[11]),
    .direct_torque_assigned(st[10]), .direct_torque_cap(st[9]),
    .alarm_present(st[0]), .warning_present(st[1]), .motor_moving(st[2]),
    .torque_at_limit(st[3]), .speed_at_set(st[4]),
    .internal_busy_in(st[5]), .overload_present(st[6]),
    .main_supply_on(st[7]), .turn_forward(st[8]), .forward_run(fn[0]),
    .backward_run(fn[1]), .stop_decel(fn[2]), .brake_release(fn[3]),
    .panel_unlock(fn[4]), .torque_cap_enable(fn[5]), .data_select(dsel),
    .general_bit(gen), .link_status_bit(stat));
  riosm_link_master i_riosm_link_master (.pclk(pclk), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial forever #20 pclk = ~pclk;
  function automatic logic [41:0] model();
    logic [5:0] f = 0;
    logic [3:0] d = 0;
    logic [15:0] g = 0, s = 0;
    logic pa = 1, ta = 1;
    logic [47:0] src;
    for (int i = 0; i < 16; i++) begin
      case (imap[i]) inside
        1, 2, 3, 4: f[imap[i] - 1] |= cmd[i];
        5: pa &= cmd[i];
        6, 7, 8, 9: d[imap[i] - 6] |= cmd[i];
        10: ta &= cmd[i];
        [16:31]: g[imap[i] - 16] |= cmd[i];
        default: ;
      endcase
    end
    f[4] = pa & (st[12] ? st[11] : 1'b1);
    f[5] = ta & (st[10] ? st[9] : 1'b1);
    src = {g, 12'h000, st[8:0], f[5], d, f[4:0], 1'b0};
    for (int i = 0; i < 16; i++)
      s[i] = omap[i] < 48 ? src[omap[i]] : 1'b0;
    return {s, g, d, f};
  endfunction
  task automatic check(string nm, logic [41:0] exp, logic [41:0] got);
    num_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(logic we, logic [11:0] a, logic [31:0] d, logic e);
    i_riosm_link_master.xfer(we, a, d, q, err, ok);
    check("answer", {ok, err}, {1'b1, e});
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
    check("ports", model(), {stat, gen, dsel, fn});
    bus(0, 12'h004, 0, 0);
    check("status", model() >> 26, q);
  endtask
  task automatic maps();
    for (int i = 0; i < 16; i++) begin
      bus(0, 12'(64 + 4 * i), 0, 0);
      check("imap", imap[i], q);
      bus(0, 12'(128 + 4 * i), 0, 0);
      check("omap", omap[i], q);
    end
  endtask
  task automatic run(int n);
    repeat (n) begin
      cmd = 16'($urandom);
      @(posedge pclk) st <= 13'($urandom);
      bus(1, 12'h000, {16'($urandom), cmd}, 0);
      settle();
      bus(0, 12'h000, 0, 0);
      check("cmd", cmd, q);
    end
  endtask
  task automatic do_reset();
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    imap = dimap;
    omap = domap;
    cmd = 16'h0000;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h7819));
    do_reset();
    settle();
    maps();
    run(30);
    bus(1, 12'h004, 32'h0000ffff, 1);
    bus(0, 12'h100, 0, 1);
    check("unmapped", 0, q);
    bus(1, 12'h042, 5, 1);
    for (int i = 0; i < 16; i++) begin
      // top bits pin panel and torque duplicates, the rest is random
      imap[i] = i > 11 ? 5 + 5 * (i & 1) : $urandom_range(31);
      omap[i] = $urandom_range(63);
      bus(1, 12'(64 + 4 * i), imap[i], 0);
      bus(1, 12'(128 + 4 * i), omap[i], 0);
    end
    maps();
    run(40);
    do_reset();
    settle();
    tally_and_finish();
  end
endmodule // tb_riosm_mapper
